// File: rtl/led_drv_pkg.sv
package led_drv_pkg;

    // shift register / latch geometry
    localparam int          SHIFT_W      = 16;
    localparam int          BIT_CNT_W    = 4;
    localparam logic [3:0]  BIT_CNT_LAST = 4'hf;
    localparam logic [3:0]  BIT_CNT_ARM  = 4'h1;
    localparam logic [15:0] SHIFT_RST    = 16'h0000;
    localparam logic [15:0] LATCH_RST    = 16'h0000;

    // word buffer between the link and the latch
    localparam int          FIFO_DEPTH   = 32;

    // system clock and inactivity timeout
    localparam int          CLK_HZ       = 20_000_000;
    localparam int          WDOG_NOM_MS  = 1000;
    localparam int          WDOG_CYCLES  = WDOG_NOM_MS * (CLK_HZ / 1000);
    localparam int          WDOG_CNT_W   = 25;

    // synchroniser reset images: {strobe, gate_b, act_tog, word_tog}
    localparam logic [3:0]  SYNC_M_RST   = 4'h4;
    localparam logic [15:0] OPEN_S_RST   = 16'h0000;

endpackage

// File: rtl/level_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module level_sync2 #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    // first stage is read only by the second
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

// File: rtl/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 32
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic      [W-1:0] out_data_out
);

    // depth must be a power of two: pointers wrap naturally
    localparam int            AW       = $clog2(DEPTH);
    localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready_out  = (cnt_q != FULL_CNT);
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            case ({push, pop})
                2'b10:   cnt_q <= cnt_q + 1'b1;
                2'b01:   cnt_q <= cnt_q - 1'b1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end

endmodule

`default_nettype wire

// File: rtl/led_shift_latch_driver_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

module led_shift_latch_driver_watchdog #(
    parameter int unsigned TIMEOUT_CYCLES = led_drv_pkg::WDOG_CYCLES
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    input  wire logic        ser_clk_in,
    input  wire logic        ser_data_in,
    output logic             ser_data_out,
    input  wire logic        latch_load_strobe_in,
    input  wire logic        out_gate_b_in,
    input  wire logic [15:0] led_open_in,
    output logic      [15:0] led_sink_outputs_out,
    output logic      [15:0] led_sink_outputs_oe_out,
    output logic             watchdog_expired_out
);

    ////////////////////////////////////////////////////////////////////////
    // link domain (serial clock)
    ////////////////////////////////////////////////////////////////////////

    logic                                  link_rst_b;
    logic [led_drv_pkg::SHIFT_W-1:0]       open_s;
    logic                                  arm_q;
    logic [led_drv_pkg::SHIFT_W-1:0]       shift_q;
    logic [led_drv_pkg::SHIFT_W-1:0]       shift_d;
    logic [led_drv_pkg::BIT_CNT_W-1:0]     bit_cnt_q;
    logic [led_drv_pkg::SHIFT_W-1:0]       word_q;
    logic                                  word_tog_q;
    logic                                  act_tog_q;

    // reset reaches the link logic only while the serial clock runs
    level_sync2 #(
        .W       (1),
        .RST_VAL (1'b0)
    ) u_link_rst_sync (
        .clk_in   (ser_clk_in),
        .rst_b_in (1'b1),
        .async_in (rst_b_in),
        .sync_out (link_rst_b)
    );

    // open-circuit sense comparators are pins: two flops first
    level_sync2 #(
        .W       (led_drv_pkg::SHIFT_W),
        .RST_VAL (led_drv_pkg::OPEN_S_RST)
    ) u_open_sync (
        .clk_in   (ser_clk_in),
        .rst_b_in (link_rst_b),
        .async_in (led_open_in),
        .sync_out (open_s)
    );

    // set straight from the strobe pin to a constant; the serial clock is
    // normally stopped when the strobe rises, so nothing else could see it
    always_ff @(posedge ser_clk_in or posedge latch_load_strobe_in) begin
        if (latch_load_strobe_in) begin
            arm_q <= 1'b1;
        end else begin
            arm_q <= 1'b0;
        end
    end

    // fault word replaces the register at the first edge after the strobe
    always_comb begin
        if (arm_q) begin
            shift_d = {open_s[led_drv_pkg::SHIFT_W-2:0], ser_data_in};
        end else begin
            shift_d = {shift_q[led_drv_pkg::SHIFT_W-2:0], ser_data_in};
        end
    end

    always_ff @(posedge ser_clk_in) begin
        if (!link_rst_b) begin
            shift_q <= led_drv_pkg::SHIFT_RST;
        end else begin
            shift_q <= shift_d;
        end
    end

    // fault msb is visible as soon as the strobe rises, no edge needed
    assign ser_data_out = arm_q ? open_s[led_drv_pkg::SHIFT_W-1]
                                : shift_q[led_drv_pkg::SHIFT_W-1];

    // word framing: count restarts from the strobe so chains stay aligned
    always_ff @(posedge ser_clk_in) begin
        if (!link_rst_b) begin
            bit_cnt_q <= '0;
        end else if (arm_q) begin
            bit_cnt_q <= led_drv_pkg::BIT_CNT_ARM;
        end else begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
        end
    end

    // each complete word is held stable and announced by a toggle
    always_ff @(posedge ser_clk_in) begin
        if (!link_rst_b) begin
            word_q     <= led_drv_pkg::SHIFT_RST;
            word_tog_q <= 1'b0;
        end else if (arm_q || bit_cnt_q == led_drv_pkg::BIT_CNT_LAST) begin
            word_q     <= shift_d;
            word_tog_q <= ~word_tog_q;
        end
    end

    // every serial edge flips this; the watchdog watches it change
    always_ff @(posedge ser_clk_in) begin
        if (!link_rst_b) begin
            act_tog_q <= 1'b0;
        end else begin
            act_tog_q <= ~act_tog_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system domain (mclk): crossing in
    ////////////////////////////////////////////////////////////////////////

    logic       strobe_s;
    logic       gate_b_s;
    logic       act_s;
    logic       word_s;
    logic       strobe_prev_q;
    logic       act_prev_q;
    logic       word_prev_q;
    logic       strobe_edge;
    logic       act_edge;
    logic       word_edge;

    level_sync2 #(
        .W       (4),
        .RST_VAL (led_drv_pkg::SYNC_M_RST)
    ) u_sys_sync (
        .clk_in   (mclk_in),
        .rst_b_in (rst_b_in),
        .async_in ({latch_load_strobe_in, out_gate_b_in, act_tog_q, word_tog_q}),
        .sync_out ({strobe_s, gate_b_s, act_s, word_s})
    );

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            strobe_prev_q <= 1'b0;
            act_prev_q    <= 1'b0;
            word_prev_q   <= 1'b0;
        end else begin
            strobe_prev_q <= strobe_s;
            act_prev_q    <= act_s;
            word_prev_q   <= word_s;
        end
    end

    assign strobe_edge = strobe_s ^ strobe_prev_q;
    assign act_edge    = act_s ^ act_prev_q;
    assign word_edge   = word_s ^ word_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // word buffer
    ////////////////////////////////////////////////////////////////////////

    logic                            push_pend_q;
    logic                            fifo_in_ready;
    logic                            fifo_out_valid;
    logic                            fifo_out_ready;
    logic [led_drv_pkg::SHIFT_W-1:0] fifo_out_data;

    // word_q is quiet for at least 15 serial clocks after its toggle, far longer
    // than the sync plus one push, so it is safe to read here
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            push_pend_q <= 1'b0;
        end else if (word_edge) begin
            push_pend_q <= 1'b1;
        end else if (fifo_in_ready) begin
            push_pend_q <= 1'b0;
        end
    end

    // drained only while the latch is open; when full the oldest word is
    // dropped, since the newest always wins at the latch anyway
    assign fifo_out_ready = strobe_s | (push_pend_q & ~fifo_in_ready);

    word_fifo #(
        .W     (led_drv_pkg::SHIFT_W),
        .DEPTH (led_drv_pkg::FIFO_DEPTH)
    ) u_word_fifo (
        .clk_in        (mclk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (push_pend_q),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (word_q),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_out_ready),
        .out_data_out  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // watchdog
    ////////////////////////////////////////////////////////////////////////

    logic [led_drv_pkg::WDOG_CNT_W-1:0] wdog_cnt_q;
    logic                               wdog_expired_q;
    logic                               wdog_fire;
    logic                               activity;

    assign activity  = act_edge | strobe_edge;
    assign wdog_fire = ~activity & ~wdog_expired_q
                     & (wdog_cnt_q == led_drv_pkg::WDOG_CNT_W'(TIMEOUT_CYCLES - 1));

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            wdog_cnt_q <= '0;
        end else if (activity) begin
            wdog_cnt_q <= '0;
        end else if (!wdog_expired_q && !wdog_fire) begin
            wdog_cnt_q <= wdog_cnt_q + 1'b1;
        end
    end

    // fires once per silence; needs fresh activity to rearm
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            wdog_expired_q <= 1'b0;
        end else if (activity) begin
            wdog_expired_q <= 1'b0;
        end else if (wdog_fire) begin
            wdog_expired_q <= 1'b1;
        end
    end

    assign watchdog_expired_out = wdog_expired_q;

    ////////////////////////////////////////////////////////////////////////
    // output latch and gate
    ////////////////////////////////////////////////////////////////////////

    logic [led_drv_pkg::SHIFT_W-1:0] latch_q;
    logic [led_drv_pkg::SHIFT_W-1:0] sink_en_q;

    // open while the strobe is high, frozen when it falls;
    // the watchdog touches only this, the shift register is left alone
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            latch_q <= led_drv_pkg::LATCH_RST;
        end else if (wdog_fire) begin
            latch_q <= led_drv_pkg::LATCH_RST;
        end else if (strobe_s && fifo_out_valid) begin
            latch_q <= fifo_out_data;
        end
    end

    // one register for all 16 lanes so the gate switches them together
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            sink_en_q <= '0;
        end else if (gate_b_s) begin
            sink_en_q <= '0;
        end else begin
            sink_en_q <= latch_q;
        end
    end

    // open drain: pull low where enabled, released elsewhere
    assign led_sink_outputs_out    = '0;
    assign led_sink_outputs_oe_out = sink_en_q;

endmodule

`default_nettype wire

// File: bench/led_drv_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none

module led_drv_checker #(
    parameter int unsigned TIMEOUT_CYCLES = 200
) (
    input wire logic        mclk_in,
    input wire logic        rst_b_in,
    input wire logic        ser_clk_in,
    input wire logic        ser_data_in,
    input wire logic        ser_data_out,
    input wire logic        latch_load_strobe_in,
    input wire logic        out_gate_b_in,
    input wire logic [15:0] led_open_in,
    input wire logic [15:0] led_sink_outputs_out,
    input wire logic [15:0] led_sink_outputs_oe_out,
    input wire logic        watchdog_expired_out
);

int quiet_q;
int edges_q;

// mclk cycles since the last pin activity
always_ff @(posedge mclk_in) begin
    if (!rst_b_in || $changed(latch_load_strobe_in) || $changed(ser_clk_in)) begin
        quiet_q <= 0;
    end else if (quiet_q < 100000) begin
        quiet_q <= quiet_q + 1;
    end
end

// strobe reloads the register with fault bits, so the bit count restarts
always_ff @(posedge ser_clk_in or posedge latch_load_strobe_in) begin
    if (latch_load_strobe_in) begin
        edges_q <= 0;
    end else if (edges_q < 100) begin
        edges_q <= edges_q + 1;
    end
end

////////////////////////////////////////////////////////////////////////
gate_off_a : assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    out_gate_b_in [*4] |-> led_sink_outputs_oe_out == 16'h0000) else $error("outputs sink while gate high");
sink_low_a : assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    led_sink_outputs_out == 16'h0000) else $error("sink data not low");
wd_clear_a : assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(watchdog_expired_out) |-> ##[0:1] led_sink_outputs_oe_out == 16'h0000) else $error("expiry left outputs on");
wd_early_a : assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(watchdog_expired_out) |-> quiet_q >= int'(TIMEOUT_CYCLES) - 4) else $error("watchdog fired early");
wd_late_a : assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    quiet_q == int'(TIMEOUT_CYCLES) + 8 |-> watchdog_expired_out) else $error("watchdog did not fire");
wd_wake_a : assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    watchdog_expired_out && $rose(latch_load_strobe_in) |-> ##[1:6] !watchdog_expired_out)
    else $error("activity did not restart watchdog");
latch_hold_a : assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (!out_gate_b_in && !latch_load_strobe_in) [*5] |=>
    $stable(led_sink_outputs_oe_out) || led_sink_outputs_oe_out == 16'h0000) else $error("latch moved, strobe low");
shift_dly_a : assert property (@(posedge ser_clk_in) disable iff (!rst_b_in)
    edges_q >= 16 |-> ser_data_out == $past(ser_data_in, 16)) else $error("cascade bit not 16 clocks late");

cover property (@(posedge mclk_in) $rose(watchdog_expired_out));
cover property (@(posedge mclk_in) $fell(out_gate_b_in));
cover property (@(posedge ser_clk_in) edges_q == 16);

endmodule

bind led_shift_latch_driver_watchdog led_drv_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ser_clk_in(ser_clk_in), .ser_data_in(ser_data_in),
    .ser_data_out(ser_data_out), .latch_load_strobe_in(latch_load_strobe_in), .out_gate_b_in(out_gate_b_in),
    .led_open_in(led_open_in), .led_sink_outputs_out(led_sink_outputs_out),
    .led_sink_outputs_oe_out(led_sink_outputs_oe_out), .watchdog_expired_out(watchdog_expired_out));

`default_nettype wire

// File: bench/led_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module led_host_model (
    output logic     ser_clk_out,
    output logic     ser_data_out,
    output logic     strobe_out,
    input wire logic cascade_in
);

initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    strobe_out = 1'b0;
end

// msb first, n bits; clock stands still outside the frame
task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    #13;
    for (int i = 15; i > 15 - n; i--) begin
        ser_data_out = w[i];
        #32;
        rx[i] = cascade_in;
        ser_clk_out = 1'b1;
        #32;
        ser_clk_out = 1'b0;
    end
    // released line must not look like held data
    ser_data_out = ~ser_data_out;
endtask

task automatic load(input int ns);
    strobe_out = 1'b1;
    #(ns);
    strobe_out = 1'b0;
    #40;
endtask

endmodule

`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;

localparam int unsigned TMO = 200;

logic        mclk;
logic        rst_b;
logic        sclk;
logic        sdin;
logic        sdout;
logic        strobe;
logic        gate_b;
logic [15:0] open_led;
logic [15:0] sink;
logic [15:0] oe;
logic        expired;
logic [15:0] rx;
logic [15:0] prev;
logic [15:0] w;
int          fails;
int          cmp_count;

always #25 mclk = ~mclk;

led_shift_latch_driver_watchdog #(.TIMEOUT_CYCLES(TMO)) uut (
    .mclk_in(mclk), .rst_b_in(rst_b), .ser_clk_in(sclk), .ser_data_in(sdin), .ser_data_out(sdout),
    .latch_load_strobe_in(strobe), .out_gate_b_in(gate_b), .led_open_in(open_led),
    .led_sink_outputs_out(sink), .led_sink_outputs_oe_out(oe), .watchdog_expired_out(expired));

led_host_model host (.ser_clk_out(sclk), .ser_data_out(sdin), .strobe_out(strobe), .cascade_in(sdout));

////////////////////////////////////////////////////////////////////////
task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
        fails++;
        $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
endtask

task automatic chk_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
        fails++;
        $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
endtask

task automatic wait_clk(input int n);
    repeat (n) @(negedge mclk);
endtask

task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
        $display("Testbench passed");
    end else begin
        $display("Testbench failed");
    end
    $finish;
endtask

////////////////////////////////////////////////////////////////////////
task automatic t_load;
    open_led = 16'h5a3c;
    host.load(600);
    host.xfer(16'hc3a5, 16, rx);
    chk_word("fault bits", 16'h5a3c, rx);
    host.load(600);
    wait_clk(12);
    chk_word("latch", 16'hc3a5, oe);
    chk_word("sink data", 16'h0000, sink);
    $display("test load done");
endtask

task automatic t_cascade;
    host.xfer(16'h1234, 16, rx);
    host.xfer(16'h0f0f, 16, rx);
    chk_word("cascade", 16'h1234, rx);
    wait_clk(4);
    chk_word("latch hold", 16'hc3a5, oe);
    host.load(600);
    wait_clk(12);
    chk_word("latch newest", 16'h0f0f, oe);
    $display("test cascade done");
endtask

task automatic t_gate;
    for (int i = 0; i < 3; i++) begin
        gate_b = 1'b1;
        wait_clk(4);
        chk_word("gate off", 16'h0000, oe);
        gate_b = 1'b0;
        wait_clk(4);
        chk_word("gate on", 16'h0f0f, oe);
    end
    $display("test gate done");
endtask

task automatic t_fill;
    // 40 words overrun the 32-word buffer; only the newest must land
    prev = 16'h5a3c;
    for (int i = 0; i < 40; i++) begin
        w = {i[7:0], ~i[7:0]};
        host.xfer(w, 16, rx);
        chk_word("chain", prev, rx);
        prev = w;
    end
    host.load(2500);
    wait_clk(12);
    chk_word("overflow newest", 16'h27d8, oe);
    $display("test fill done");
endtask

task automatic t_wdog;
    host.xfer(16'ha55a, 16, rx);
    wait_clk(TMO + 30);
    chk_bit("expired", 1'b1, expired);
    chk_word("cleared", 16'h0000, oe);
    host.xfer(16'h3c3c, 16, rx);
    chk_word("shift kept", 16'ha55a, rx);
    wait_clk(10);
    chk_word("still off", 16'h0000, oe);
    host.load(600);
    wait_clk(12);
    chk_word("recovered", 16'h3c3c, oe);
    chk_bit("expired cleared", 1'b0, expired);
    $display("test watchdog done");
endtask

////////////////////////////////////////////////////////////////////////
initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    $display("MISMATCH run time expected done seen timeout");
    end_of_test();
end

initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    gate_b = 1'b0;
    // fault sense is sampled on serial edges only, so set it before the flush
    open_led = 16'h5a3c;
    fails = 0;
    cmp_count = 0;
    // link reset needs serial edges to clear
    fork
        wait_clk(10);
        host.xfer(16'h0000, 4, rx);
    join
    rst_b = 1'b1;
    // link reset lifts two serial edges after release; flush a frame so the
    // first strobe sees a live shift register and synced fault sense
    host.xfer(16'h0000, 16, rx);
    wait_clk(2);
    t_load();
    t_cascade();
    t_gate();
    t_fill();
    t_wdog();
    end_of_test();
end

endmodule

`default_nettype wire
